// ### include/qup_pkg.sv
// Package of constants shared by the quad serial pin-signalling block.
package qup_pkg;
  localparam int QUP_CHANNELS = 4;
  localparam int QUP_ADDR_W = 5;
  localparam int QUP_MCR_W = 8;
  localparam int QUP_MCR_SEND_REQ_BIT = 1;
  localparam int QUP_MCR_AUTO_FLOW_BIT = 5;
  localparam int QUP_MCR_LOOPBACK_BIT = 4;
  localparam logic [7:0] QUP_MCR_RESET = 8'h00;
  localparam logic [4:0] QUP_ADDR_MCR = 5'h04;
  localparam logic [4:0] QUP_ADDR_RHR = 5'h00;
  localparam logic [4:0] QUP_ADDR_RING = 5'h06;
  localparam logic [3:0] QUP_FIFO_DEPTH = 4'hF;
  localparam logic QUP_LINE_IDLE = 1'b1;
  localparam logic QUP_PIN_INACTIVE = 1'b1;
  localparam logic QUP_MODE_ALT = 1'b0;
  localparam logic QUP_STROBE_READ = 1'b1;
  typedef enum logic [1:0] {
    QUP_BUS_IDLE = 2'b00,
    QUP_BUS_READ = 2'b01,
    QUP_BUS_WRITE = 2'b10
  } qup_bus_state_t;
endpackage : qup_pkg

// ### include/qup_chan_if.sv
// Interface joining the top level to one channel's pin logic.
interface qup_chan_if;
  logic mcr_wr;
  logic [7:0] mcr_data;
  logic rhr_rd;
  logic rx_char_valid;
  logic [7:0] rx_char;
  logic tx_serial;
  logic ring_pin;
  logic rx_pin;
  logic send_request;
  logic ring_event;
  logic rx_ready_n;
  logic [3:0] rx_count;
  logic [7:0] modem_control_reg;
  logic line_level;
  modport top (output mcr_wr, mcr_data, rhr_rd, rx_char_valid, rx_char, tx_serial,
               ring_pin, rx_pin,
               input send_request, ring_event, rx_ready_n, rx_count, modem_control_reg, line_level);
  modport chan (input mcr_wr, mcr_data, rhr_rd, rx_char_valid, rx_char, tx_serial,
                ring_pin, rx_pin,
                output send_request, ring_event, rx_ready_n, rx_count, modem_control_reg, line_level);
endinterface : qup_chan_if

// ### rtl/qup_channel.sv
// One channel: ring detect, send request control and receive line state.
module qup_channel
  import qup_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_int_n,
  qup_chan_if.chan ch
);
  logic [7:0] mcr_reg;
  logic ring_prev_reg;
  logic ring_event_reg;
  logic send_request_reg;
  logic line_reg;
  logic [3:0] count_reg;
  logic rx_ready_n_reg;
  logic [3:0] count_next;

  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      mcr_reg <= QUP_MCR_RESET;
    end else if (ch.mcr_wr) begin
      mcr_reg <= ch.mcr_data;
    end
  end

  // Pin is low while the request bit is one; reset leaves it high. [RULE_03] [RULE_04]
  // The auto flow bit only matters to the transmit/receive path, not to this pin. [RULE_05]
  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      send_request_reg <= QUP_PIN_INACTIVE;
    end else begin
      send_request_reg <= ~mcr_reg[QUP_MCR_SEND_REQ_BIT];
    end
  end

  // Low ring pin means ringing; a rise ends it and raises a one-cycle event. [RULE_01] [RULE_02]
  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ring_prev_reg <= QUP_PIN_INACTIVE;
      ring_event_reg <= 1'b0;
    end else begin
      ring_prev_reg <= ch.ring_pin;
      ring_event_reg <= ch.ring_pin & ~ring_prev_reg;
    end
  end

  // Loopback ignores the pin and feeds transmit data back; idle is high. [RULE_07] [RULE_08]
  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      line_reg <= QUP_LINE_IDLE;
    end else if (mcr_reg[QUP_MCR_LOOPBACK_BIT]) begin
      line_reg <= ch.tx_serial;
    end else begin
      line_reg <= ch.rx_pin;
    end
  end

  // Count of unread characters; a push in the same cycle as a pop keeps the count.
  always_comb begin
    count_next = count_reg;
    if (ch.rx_char_valid && count_reg != QUP_FIFO_DEPTH && !(ch.rhr_rd && count_reg != 4'h0)) begin
      count_next = count_reg + 4'h1;
    end else if (ch.rhr_rd && count_reg != 4'h0 && !ch.rx_char_valid) begin
      count_next = count_reg - 4'h1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      count_reg <= 4'h0;
    end else begin
      count_reg <= count_next;
    end
  end

  // Ready is low with any unread character, high once empty. [RULE_10] [RULE_11]
  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rx_ready_n_reg <= QUP_PIN_INACTIVE;
    end else begin
      rx_ready_n_reg <= (count_next == 4'h0);
    end
  end

  assign ch.send_request = send_request_reg;
  assign ch.ring_event = ring_event_reg;
  assign ch.rx_ready_n = rx_ready_n_reg;
  assign ch.rx_count = count_reg;
  assign ch.modem_control_reg = mcr_reg;
  assign ch.line_level = line_reg;
endmodule : qup_channel

// ### rtl/qup_top.sv
// Top level of the quad serial pin-signalling block.
// Summary of operation
// (RULE_01) Ring input low means the modem sees a ringing line.
// (RULE_02) Ring input rising high raises that channel's interrupt.
// (RULE_03) Modem control bit 1 set drives the send request pin low.
// (RULE_04) Send request pins are high after reset.
// (RULE_05) Send request only steers data flow when auto flow bit 5 is set.
// (RULE_06) Alternate bus mode: strobe high reads, low writes the selected register.
// (RULE_07) Receive line idles high; reset, idle and disabled all read high.
// (RULE_08) Loopback ignores the receive pin and feeds transmit data to the receiver.
// (RULE_09) One active low receive ready output combines all four channels.
// (RULE_10) A channel is ready when it holds at least one unread character.
// (RULE_11) Ready returns high once no characters remain.
// (RULE_12) Reset pin is high active in standard mode, low active in alternate.
// (RULE_13) Per-channel logic is instantiated four times, fully independent.
module qup_top
  import qup_pkg::*;
#(
  parameter int CHANNELS = QUP_CHANNELS
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic reset_pin_in,
  input wire logic bus_mode_in,
  input wire logic chip_select_n_in,
  input wire logic [4:0] addr_in,
  input wire logic read_write_in,
  input wire logic [7:0] wdata_in,
  input wire logic [3:0] ring_indicate_in,
  input wire logic [3:0] serial_in,
  input wire logic [3:0] tx_serial_in,
  input wire logic [3:0] rx_char_valid_in,
  input wire logic [31:0] rx_char_in,
  output logic [3:0] send_request_out,
  output logic [3:0] ring_irq_out,
  output logic receive_ready_any_out,
  output logic [3:0] line_level_out,
  output logic [3:0] auto_flow_out,
  output logic [7:0] rdata_out,
  output logic rdata_valid_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: the decode below is written for this exact geometry.
  if (CHANNELS != QUP_CHANNELS) begin : g_bad_channels
    $error("qup_top serves exactly four channels");
  end
  if (QUP_ADDR_W != 5) begin : g_bad_addr
    $error("qup_top decodes a five bit address");
  end
  if (QUP_MCR_SEND_REQ_BIT >= QUP_MCR_W) begin : g_bad_req_bit
    $error("send request bit lies outside the control register");
  end
  if (QUP_MCR_AUTO_FLOW_BIT >= QUP_MCR_W) begin : g_bad_flow_bit
    $error("auto flow bit lies outside the control register");
  end
  if (QUP_MCR_LOOPBACK_BIT >= QUP_MCR_W) begin : g_bad_loop_bit
    $error("loopback bit lies outside the control register");
  end
  if (QUP_ADDR_MCR == QUP_ADDR_RHR || QUP_ADDR_MCR == QUP_ADDR_RING) begin : g_bad_map
    $error("register addresses overlap");
  end
  if (QUP_FIFO_DEPTH == 4'h0) begin : g_bad_depth
    $error("receive capacity must be at least one character");
  end
  // A reset value with the request bit set would assert the pin out of reset.
  if (QUP_MCR_RESET[QUP_MCR_SEND_REQ_BIT] != 1'b0) begin : g_bad_mcr_reset
    $error("control register reset value must leave the request bit clear");
  end
  if (QUP_LINE_IDLE != 1'b1 || QUP_PIN_INACTIVE != 1'b1) begin : g_bad_levels
    $error("idle and inactive pin levels must be high");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset: the pin is high active in standard mode, low active in alternate.
  // The pin is treated as a synchronous level, so it feeds a clocked stage whose output
  // then drives the asynchronous clear; this avoids glitch resets from the host side.
  logic pin_reset_req;
  logic pin_reset_reg;
  logic rst_int_n;

  always_comb begin
    case (bus_mode_in)
      QUP_MODE_ALT: begin
        pin_reset_req = ~reset_pin_in; // [RULE_12]
      end
      default: begin
        pin_reset_req = reset_pin_in; // [RULE_12]
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_reset_reg <= 1'b1;
    end else begin
      pin_reset_reg <= pin_reset_req; // [RULE_12]
    end
  end

  assign rst_int_n = rstn_in & ~pin_reset_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Host strobe decode in alternate mode.
  qup_bus_state_t bus_state;
  logic bus_write;
  logic bus_read;
  logic [4:0] addr_reg;
  logic [1:0] chan_sel;
  logic [2:0] reg_sel;
  logic sel_mcr;
  logic sel_rhr;
  logic sel_ring;
  logic addr_moved;
  logic [3:0] mcr_wr_vec;
  logic [3:0] rhr_rd_vec;

  always_comb begin
    bus_state = QUP_BUS_IDLE;
    if (!chip_select_n_in && bus_mode_in == QUP_MODE_ALT) begin
      bus_state = (read_write_in == QUP_STROBE_READ) ? QUP_BUS_READ : QUP_BUS_WRITE; // [RULE_06]
    end
  end

  // Standard mode accesses never leave the idle state, so they are refused here.
  always_comb begin
    bus_write = 1'b0;
    bus_read = 1'b0;
    case (bus_state)
      QUP_BUS_READ: begin
        bus_read = 1'b1;
      end
      QUP_BUS_WRITE: begin
        bus_write = 1'b1;
      end
      default: begin
        bus_write = 1'b0;
        bus_read = 1'b0;
      end
    endcase
  end

  assign chan_sel = addr_in[4:3];
  assign reg_sel = addr_in[2:0];
  assign sel_mcr = ({2'b00, reg_sel} == QUP_ADDR_MCR);
  assign sel_rhr = ({2'b00, reg_sel} == QUP_ADDR_RHR);
  assign sel_ring = ({2'b00, reg_sel} == QUP_ADDR_RING);
  // Only a read whose address differs from the last cycle's pops, so a held read pops at most once.
  assign addr_moved = (addr_reg != addr_in);

  always_comb begin
    mcr_wr_vec = 4'h0;
    rhr_rd_vec = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (chan_sel == 2'(i)) begin
        mcr_wr_vec[i] = bus_write && sel_mcr; // [RULE_06]
        rhr_rd_vec[i] = bus_read && sel_rhr && addr_moved; // [RULE_06]
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      addr_reg <= 5'h00;
    end else begin
      addr_reg <= addr_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels.
  qup_chan_if ch_if [4] ();
  logic [3:0] ready_n;
  logic [3:0] ring_evt;
  logic [3:0] sreq;
  logic [3:0] line;
  logic [3:0] auto_flow;
  logic [7:0] mcr_rd [4];
  logic [7:0] cnt_rd [4];

  for (genvar i = 0; i < 4; i++) begin : g_ch
    assign ch_if[i].mcr_wr = mcr_wr_vec[i]; // [RULE_06]
    assign ch_if[i].mcr_data = wdata_in;
    assign ch_if[i].rhr_rd = rhr_rd_vec[i];
    assign ch_if[i].rx_char_valid = rx_char_valid_in[i];
    assign ch_if[i].rx_char = rx_char_in[8*i +: 8];
    assign ch_if[i].tx_serial = tx_serial_in[i];
    assign ch_if[i].ring_pin = ring_indicate_in[i];
    assign ch_if[i].rx_pin = serial_in[i];
    assign ready_n[i] = ch_if[i].rx_ready_n;
    assign ring_evt[i] = ch_if[i].ring_event;
    assign sreq[i] = ch_if[i].send_request;
    assign line[i] = ch_if[i].line_level;
    assign auto_flow[i] = ch_if[i].modem_control_reg[QUP_MCR_AUTO_FLOW_BIT];
    assign mcr_rd[i] = ch_if[i].modem_control_reg;
    assign cnt_rd[i] = {4'h0, ch_if[i].rx_count};

    qup_channel u_chan ( // [RULE_13]
      .clock_in(clock_in),
      .rst_int_n(rst_int_n),
      .ch(ch_if[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each from a flip-flop of its own concern.
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = cnt_rd[chan_sel];
    if (sel_mcr) begin
      rdata_next = mcr_rd[chan_sel];
    end else if (sel_ring) begin
      rdata_next = {4'h0, ring_indicate_in};
    end
  end

  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      send_request_out <= 4'hF;
    end else begin
      send_request_out <= sreq; // [RULE_03] [RULE_04]
    end
  end

  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ring_irq_out <= 4'h0;
    end else begin
      ring_irq_out <= ring_evt; // [RULE_02]
    end
  end

  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      line_level_out <= 4'hF;
    end else begin
      line_level_out <= line; // [RULE_07]
    end
  end

  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      auto_flow_out <= 4'h0;
    end else begin
      auto_flow_out <= auto_flow; // [RULE_05]
    end
  end

  // Active low wired-OR: low when any channel holds data. [RULE_09]
  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      receive_ready_any_out <= 1'b1;
    end else begin
      receive_ready_any_out <= &ready_n;
    end
  end

  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rdata_valid_out <= 1'b0;
    end else begin
      rdata_valid_out <= bus_read; // [RULE_06]
    end
  end

  // Read data holds its last value between reads.
  always_ff @(posedge clock_in or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rdata_out <= 8'h00;
    end else if (bus_read) begin
      rdata_out <= rdata_next; // [RULE_06]
    end
  end
endmodule : qup_top

// ### tb/qup_props.sv
// Checker of the pin-signalling block's port behaviour.
module qup_props (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic bus_mode_in,
  input wire logic chip_select_n_in,
  input wire logic [4:0] addr_in,
  input wire logic read_write_in,
  input wire logic [7:0] wdata_in,
  input wire logic [3:0] ring_indicate_in,
  input wire logic [3:0] rx_char_valid_in,
  input wire logic [3:0] send_request_out,
  input wire logic [3:0] ring_irq_out,
  input wire logic receive_ready_any_out,
  input wire logic [3:0] line_level_out,
  input wire logic rdata_valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  logic acc;
  logic wr;
  logic rd;
  assign acc = !chip_select_n_in && !bus_mode_in;
  assign wr = acc && !read_write_in && addr_in[2:0] == 3'h4;
  assign rd = acc && read_write_in;
  ////////////////////////////////////////////////////////////////////////////////
  reset_idle_a: assert property (
    $rose(rstn_in) |-> send_request_out == 4'hF && line_level_out == 4'hF)
    else $error("outputs not idle after reset");
  ready_reset_a: assert property (
    $rose(rstn_in) |-> receive_ready_any_out) else $error("ready low after reset");
  send_req_a: assert property (
    wr |-> ##3 send_request_out[$past(addr_in[4:3], 3)] == !$past(wdata_in[1], 3))
    else $error("send request does not follow control bit");
  ring_rise_a: assert property (
    $rose(ring_indicate_in[0]) |-> ##2 ring_irq_out[0]) else $error("ring rise lost");
  ring_cause_a: assert property (
    ring_irq_out[1] |-> $past(ring_indicate_in[1], 2) && !$past(ring_indicate_in[1], 3))
    else $error("ring interrupt without rise");
  ring_pulse_a: assert property (
    ring_irq_out[2] |=> !ring_irq_out[2]) else $error("ring interrupt too long");
  ready_set_a: assert property (
    |rx_char_valid_in |-> ##2 !receive_ready_any_out) else $error("ready not set");
  read_ans_a: assert property (
    rd |=> rdata_valid_out) else $error("read not answered");
  read_only_a: assert property (
    rdata_valid_out |-> $past(rd)) else $error("answer without read");
  cover property (wr && wdata_in[1]);
  cover property ($rose(ring_irq_out[3]));
  cover property (rd ##1 rdata_valid_out);
endmodule : qup_props
bind qup_top qup_props i_props (.clock_in, .rstn_in, .bus_mode_in, .chip_select_n_in,
  .addr_in, .read_write_in, .wdata_in, .ring_indicate_in, .rx_char_valid_in,
  .send_request_out, .ring_irq_out, .receive_ready_any_out, .line_level_out,
  .rdata_valid_out);

// ### tb/qup_peer.sv
// Behavioural model of the modem and serial line facing the block.
module qup_peer (
  input wire logic [3:0] ringing_in,
  input wire logic [3:0] line_drive_in,
  input wire logic [3:0] line_bits_in,
  output logic [3:0] ring_indicate_out,
  output logic [3:0] serial_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // A ringing line is reported as a low level.
  assign ring_indicate_out = ~ringing_in;
  // An undriven line rests high, as its pull-up would hold it.
  assign serial_out = line_bits_in | ~line_drive_in;
endmodule : qup_peer

// ### tb/tb.sv
// Self-checking testbench of the quad pin-signalling block.
module tb;
  import qup_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'h0;
  logic rstn_in = 1'h0;
  logic cs_n = 1'h1;
  logic rw = 1'h1;
  logic pin_rst = 1'h1;
  logic mode = 1'h0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic [3:0] ringing = 4'h0, drive = 4'h0, bits = 4'h0, txd = 4'h0, cval = 4'h0;
  logic [3:0] ring_n, rxd, srq, irq, level, aflow;
  logic ready_n, rvalid;
  logic [7:0] rdata;
  int fails = 0;
  int checked = 0;
  qup_top i_dut (.clock_in, .rstn_in, .reset_pin_in(pin_rst), .bus_mode_in(mode),
    .chip_select_n_in(cs_n), .addr_in(addr), .read_write_in(rw), .wdata_in(wdata),
    .ring_indicate_in(ring_n), .serial_in(rxd), .tx_serial_in(txd),
    .rx_char_valid_in(cval), .rx_char_in(32'h0), .send_request_out(srq),
    .ring_irq_out(irq), .receive_ready_any_out(ready_n), .line_level_out(level),
    .auto_flow_out(aflow), .rdata_out(rdata), .rdata_valid_out(rvalid));
  qup_peer i_peer (.ringing_in(ringing), .line_drive_in(drive), .line_bits_in(bits),
    .ring_indicate_out(ring_n), .serial_out(rxd));
  initial forever #50 clock_in = ~clock_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wait_look(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wait_look
  // Requests start and end on edges, so the block never sees a half-changed access.
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_in);
    cs_n <= 1'h0;
    rw <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    cs_n <= 1'h1;
  endtask : bus
  task automatic t_send();
    for (int c = 0; c < 4; c++) begin
      bus(1'h1, {c[1:0], 3'h4}, 8'h22);
      wait_look(2);
      check("send_request", 8'h0F & ~(8'h01 << c), {4'h0, srq});
      bus(1'h0, {c[1:0], 3'h4}, 8'h00);
      #1;
      check("rdata_valid", 8'h01, {7'h0, rvalid});
      check("mcr", 8'h22, rdata);
      check("auto_flow", 8'h01 << c, {4'h0, aflow});
      bus(1'h1, {c[1:0], 3'h4}, 8'h00);
      wait_look(2);
      check("send_request", 8'h0F, {4'h0, srq});
    end
    $display("test send done");
  endtask : t_send
  task automatic t_ring();
    for (int c = 0; c < 4; c++) begin
      @(posedge clock_in);
      ringing <= 4'h1 << c;
      @(posedge clock_in);
      ringing <= 4'h0;
      wait_look(2);
      check("ring_irq", 8'h01 << c, {4'h0, irq});
      wait_look(1);
      check("ring_irq", 8'h00, {4'h0, irq});
    end
    $display("test ring done");
  endtask : t_ring
  task automatic t_ready();
    @(posedge clock_in);
    cval <= 4'h9;
    @(posedge clock_in);
    cval <= 4'h0;
    wait_look(1);
    check("ready_n", 8'h00, {7'h0, ready_n});
    bus(1'h0, 5'h00, 8'h00);
    wait_look(2);
    check("ready_n", 8'h00, {7'h0, ready_n});
    check("rdata", 8'h01, rdata);
    bus(1'h0, 5'h18, 8'h00);
    wait_look(2);
    check("ready_n", 8'h01, {7'h0, ready_n});
    $display("test ready done");
  endtask : t_ready
  task automatic t_loop();
    @(posedge clock_in);
    drive <= 4'h2;
    wait_look(3);
    check("line_level", 8'h0D, {4'h0, level});
    bus(1'h1, 5'h0C, 8'h10);
    txd <= 4'h2;
    wait_look(3);
    check("line_level", 8'h0F, {4'h0, level});
    @(posedge clock_in);
    txd <= 4'h0;
    wait_look(3);
    check("line_level", 8'h0D, {4'h0, level});
    $display("test loopback done");
  endtask : t_loop
  task automatic t_pin_reset();
    bus(1'h1, 5'h14, 8'h02);
    wait_look(2);
    check("send_request", 8'h0B, {4'h0, srq});
    @(posedge clock_in);
    mode <= 1'h1;
    pin_rst <= 1'h0;
    bus(1'h1, 5'h14, 8'h00);
    wait_look(2);
    check("send_request", 8'h0B, {4'h0, srq});
    @(posedge clock_in);
    pin_rst <= 1'h1;
    wait_look(2);
    check("send_request", 8'h0F, {4'h0, srq});
    @(posedge clock_in);
    mode <= 1'h0;
    wait_look(1);
    bus(1'h1, 5'h14, 8'h02);
    wait_look(2);
    check("send_request", 8'h0B, {4'h0, srq});
    @(posedge clock_in);
    pin_rst <= 1'h0;
    wait_look(2);
    check("send_request", 8'h0F, {4'h0, srq});
    @(posedge clock_in);
    pin_rst <= 1'h1;
    wait_look(2);
    $display("test reset pin done");
  endtask : t_pin_reset
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (5) @(posedge clock_in);
    rstn_in <= 1'h1;
    wait_look(1);
    check("send_request", 8'h0F, {4'h0, srq});
    check("line_level", 8'h0F, {4'h0, level});
    check("ready_n", 8'h01, {7'h0, ready_n});
    $display("test reset done");
    t_send();
    t_ring();
    t_ready();
    t_loop();
    t_pin_reset();
    summarize();
  end
  // The tests need well under 200 clock cycles; this limit leaves wide margin.
  initial begin
    #200000;
    fails++;
    summarize();
  end
endmodule : tb
